/* common/emg_consts.vh */
`ifndef EMG_CONSTS_VH
`define EMG_CONSTS_VH

// Register offsets.
`define EMG_ADDR_ENG1_HI       8'h70
`define EMG_ADDR_ENG1_LO       8'h71
`define EMG_ADDR_ENG2_HI       8'h72
`define EMG_ADDR_ENG2_LO       8'h73
`define EMG_ADDR_ENG3_HI       8'h74
`define EMG_ADDR_ENG3_LO       8'h75
`define EMG_ADDR_GAIN_CTRL     8'h76

// Field positions of the high mapping bytes.
`define EMG_HI_GPO_BIT         7
`define EMG_HI_OUT9_BIT        0

// Field positions of the gain change control register.
`define EMG_GAIN_THR_HI        7
`define EMG_GAIN_THR_LO        6
`define EMG_GAIN_ADAPT_BIT     5
`define EMG_GAIN_TSEL_HI       4
`define EMG_GAIN_TSEL_LO       3
`define EMG_GAIN_TEN_BIT       2

// Reset values.
`define EMG_MAP_RESET          8'h00
`define EMG_GAIN_RESET         6'h00

// Timer period select codes.
`define EMG_TSEL_5MS           2'h0
`define EMG_TSEL_10MS          2'h1
`define EMG_TSEL_50MS          2'h2
`define EMG_TSEL_INF           2'h3

// Timing.
`define EMG_CLK_MHZ            25
`define EMG_T5_US              5000
`define EMG_T10_US             10000
`define EMG_T50_US             50000
`define EMG_CYC_5MS            (`EMG_T5_US * `EMG_CLK_MHZ)
`define EMG_CYC_10MS           (`EMG_T10_US * `EMG_CLK_MHZ)
`define EMG_CYC_50MS           (`EMG_T50_US * `EMG_CLK_MHZ)

// Serial bus device address base; the value is arbitrary.
`define EMG_DEV_ADDR_BASE      7'h32

`endif

/* rtl/emg_gain_timer.v */
`timescale 1ns/1ps
`include "emg_consts.vh"

module emg_gain_timer #(
    parameter CNT_W    = 21,
    parameter CNT_5MS  = `EMG_CYC_5MS,
    parameter CNT_10MS = `EMG_CYC_10MS,
    parameter CNT_50MS = `EMG_CYC_50MS
) (
    // Clock and reset.
    input  wire             mclk,
    input  wire             rst_b,
    // Control.
    input  wire             timer_en,
    input  wire [1:0]       period_sel,
    input  wire             gain_is_1p5,
    // Result.
    output reg              return_1x_ff
);

    reg  [CNT_W-1:0] cnt_ff;
    reg  [CNT_W-1:0] limit;
    wire             run;

    always @* begin
        case (period_sel)
            `EMG_TSEL_5MS:  limit = CNT_5MS[CNT_W-1:0];
            `EMG_TSEL_10MS: limit = CNT_10MS[CNT_W-1:0];
            `EMG_TSEL_50MS: limit = CNT_50MS[CNT_W-1:0];
            default:        limit = {CNT_W{1'b0}};
        endcase
    end

    assign run = timer_en & gain_is_1p5 & (period_sel != `EMG_TSEL_INF);

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_ff       <= {CNT_W{1'b0}};
            return_1x_ff <= 1'b0;
        end else if (!run) begin
            cnt_ff       <= {CNT_W{1'b0}};
            return_1x_ff <= 1'b0;
        end else if (cnt_ff >= limit - 1'b1) begin
            cnt_ff       <= {CNT_W{1'b0}};
            return_1x_ff <= 1'b1;
        end else begin
            cnt_ff       <= cnt_ff + 1'b1;
            return_1x_ff <= 1'b0;
        end
    end

endmodule

/* rtl/emg_map_gain_regs.v */
`timescale 1ns/1ps
`include "emg_consts.vh"

module emg_map_gain_regs #(
    parameter CNT_5MS  = `EMG_CYC_5MS,
    parameter CNT_10MS = `EMG_CYC_10MS,
    parameter CNT_50MS = `EMG_CYC_50MS
) (
    // Clock and reset.
    input  wire       mclk,
    input  wire       rst_b,
    // Two-wire serial bus.
    input  wire       scl_in,
    input  wire       sda_in,
    output wire       sda_out,
    output reg        sda_oe_ff,
    input  wire [1:0] addr_sel,
    // Engine ownership of outputs.
    input  wire [8:0] eng1_led_map,
    input  wire       eng1_gpo_map,
    input  wire [8:0] eng2_led_map,
    input  wire       eng2_gpo_map,
    input  wire [8:0] eng3_led_map,
    input  wire       eng3_gpo_map,
    // Charge pump control.
    input  wire       gain_is_1p5,
    output wire [1:0] gain_change_threshold_select,
    output wire       adaptive_threshold_enable,
    output wire       gain_return_timer_enable,
    output wire [1:0] gain_return_period_select,
    output wire       gain_return_1x
);

    localparam ST_IDLE = 3'h0;
    localparam ST_ADDR = 3'h1;
    localparam ST_ACKA = 3'h2;
    localparam ST_WR   = 3'h3;
    localparam ST_ACKW = 3'h4;
    localparam ST_RD   = 3'h5;
    localparam ST_RACK = 3'h6;

    // Fixed upper part of the device address.
    localparam [6:0] DEV_BASE = `EMG_DEV_ADDR_BASE;

    // Synchronisers and edge history.
    reg  [1:0] scl_sync_ff;
    reg  [1:0] sda_sync_ff;
    reg  [1:0] asel_sync1_ff;
    reg  [1:0] asel_sync2_ff;
    reg        scl_d_ff;
    reg        sda_d_ff;
    wire       scl_s;
    wire       sda_s;
    wire       scl_rise;
    wire       scl_fall;
    wire       bus_start;
    wire       bus_stop;
    wire [6:0] dev_addr;
    wire [7:0] rd_byte;

    // Protocol state.
    reg  [2:0] state_ff;
    reg  [3:0] bit_cnt_ff;
    reg  [7:0] shift_ff;
    reg  [7:0] tx_ff;
    reg  [7:0] ptr_ff;
    reg        first_ff;
    reg        acked_ff;

    // Register contents.
    reg  [7:0] eng1_hi_ff;
    reg  [7:0] eng1_lo_ff;
    reg  [7:0] eng2_hi_ff;
    reg  [7:0] eng2_lo_ff;
    reg  [7:0] eng3_hi_ff;
    reg  [7:0] eng3_lo_ff;
    reg  [5:0] gain_ff;

    function [7:0] hi_byte;
        input       general_output_pin;
        input       out9;
        begin
            hi_byte = 8'h00;
            hi_byte[`EMG_HI_GPO_BIT]  = general_output_pin;
            hi_byte[`EMG_HI_OUT9_BIT] = out9;
        end
    endfunction

    function [7:0] read_reg;
        input [7:0] a;
        begin
            case (a)
                `EMG_ADDR_ENG1_HI:   read_reg = eng1_hi_ff;
                `EMG_ADDR_ENG1_LO:   read_reg = eng1_lo_ff;
                `EMG_ADDR_ENG2_HI:   read_reg = eng2_hi_ff;
                `EMG_ADDR_ENG2_LO:   read_reg = eng2_lo_ff;
                `EMG_ADDR_ENG3_HI:   read_reg = eng3_hi_ff;
                `EMG_ADDR_ENG3_LO:   read_reg = eng3_lo_ff;
                `EMG_ADDR_GAIN_CTRL: read_reg = {gain_ff, 2'h0};
                default:             read_reg = 8'h00;
            endcase
        end
    endfunction

    // Open drain pin only ever pulls low.
    assign sda_out = 1'b0;

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            scl_sync_ff   <= 2'h3;
            sda_sync_ff   <= 2'h3;
            asel_sync1_ff <= 2'h0;
            asel_sync2_ff <= 2'h0;
            scl_d_ff      <= 1'b1;
            sda_d_ff      <= 1'b1;
        end else begin
            scl_sync_ff   <= {scl_sync_ff[0], scl_in};
            sda_sync_ff   <= {sda_sync_ff[0], sda_in};
            asel_sync1_ff <= addr_sel;
            asel_sync2_ff <= asel_sync1_ff;
            scl_d_ff      <= scl_sync_ff[1];
            sda_d_ff      <= sda_sync_ff[1];
        end
    end

    assign scl_s     = scl_sync_ff[1];
    assign sda_s     = sda_sync_ff[1];
    assign scl_rise  = scl_s & ~scl_d_ff;
    assign scl_fall  = ~scl_s & scl_d_ff;
    assign bus_start = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
    assign bus_stop  = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
    assign dev_addr  = {DEV_BASE[6:2], asel_sync2_ff};
    assign rd_byte   = read_reg(ptr_ff);

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff   <= ST_IDLE;
            bit_cnt_ff <= 4'h0;
            shift_ff   <= 8'h00;
            tx_ff      <= 8'h00;
            ptr_ff     <= 8'h00;
            first_ff   <= 1'b0;
            acked_ff   <= 1'b0;
            sda_oe_ff  <= 1'b0;
            gain_ff    <= `EMG_GAIN_RESET;
        end else if (bus_stop) begin
            state_ff  <= ST_IDLE;
            sda_oe_ff <= 1'b0;
        end else if (bus_start) begin
            state_ff   <= ST_ADDR;
            bit_cnt_ff <= 4'h0;
            sda_oe_ff  <= 1'b0;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    sda_oe_ff <= 1'b0;
                end
                ST_ADDR: begin
                    if (scl_rise) begin
                        shift_ff   <= {shift_ff[6:0], sda_s};
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    end else if (scl_fall && bit_cnt_ff == 4'h8) begin
                        if (shift_ff[7:1] == dev_addr) begin
                            acked_ff  <= shift_ff[0];
                            sda_oe_ff <= 1'b1;
                            state_ff  <= ST_ACKA;
                        end else begin
                            state_ff <= ST_IDLE;
                        end
                    end
                end
                ST_ACKA: begin
                    if (scl_fall) begin
                        bit_cnt_ff <= 4'h0;
                        if (acked_ff) begin
                            tx_ff     <= read_reg(ptr_ff);
                            sda_oe_ff <= ~rd_byte[7];
                            state_ff  <= ST_RD;
                        end else begin
                            sda_oe_ff <= 1'b0;
                            first_ff  <= 1'b1;
                            state_ff  <= ST_WR;
                        end
                    end
                end
                ST_WR: begin
                    if (scl_rise) begin
                        shift_ff   <= {shift_ff[6:0], sda_s};
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    end else if (scl_fall && bit_cnt_ff == 4'h8) begin
                        sda_oe_ff <= 1'b1;
                        state_ff  <= ST_ACKW;
                        if (first_ff) begin
                            ptr_ff   <= shift_ff;
                            first_ff <= 1'b0;
                        end else begin
                            if (ptr_ff == `EMG_ADDR_GAIN_CTRL) begin
                                gain_ff <= shift_ff[7:2];
                            end
                            ptr_ff <= ptr_ff + 8'h01;
                        end
                    end
                end
                ST_ACKW: begin
                    if (scl_fall) begin
                        sda_oe_ff  <= 1'b0;
                        bit_cnt_ff <= 4'h0;
                        state_ff   <= ST_WR;
                    end
                end
                ST_RD: begin
                    if (scl_fall) begin
                        if (bit_cnt_ff == 4'h7) begin
                            sda_oe_ff <= 1'b0;
                            ptr_ff    <= ptr_ff + 8'h01;
                            state_ff  <= ST_RACK;
                        end else begin
                            bit_cnt_ff <= bit_cnt_ff + 4'h1;
                            tx_ff      <= {tx_ff[6:0], 1'b0};
                            sda_oe_ff  <= ~tx_ff[6];
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        acked_ff <= ~sda_s;
                    end else if (scl_fall) begin
                        bit_cnt_ff <= 4'h0;
                        if (acked_ff) begin
                            tx_ff     <= read_reg(ptr_ff);
                            sda_oe_ff <= ~rd_byte[7];
                            state_ff  <= ST_RD;
                        end else begin
                            state_ff <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_ff  <= ST_IDLE;
                    sda_oe_ff <= 1'b0;
                end
            endcase
        end
    end

    // Mapping bytes follow the engines only.
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            eng1_hi_ff <= `EMG_MAP_RESET;
            eng1_lo_ff <= `EMG_MAP_RESET;
            eng2_hi_ff <= `EMG_MAP_RESET;
            eng2_lo_ff <= `EMG_MAP_RESET;
            eng3_hi_ff <= `EMG_MAP_RESET;
            eng3_lo_ff <= `EMG_MAP_RESET;
        end else begin
            eng1_hi_ff <= hi_byte(eng1_gpo_map, eng1_led_map[8]);
            eng1_lo_ff <= eng1_led_map[7:0];
            eng2_hi_ff <= hi_byte(eng2_gpo_map, eng2_led_map[8]);
            eng2_lo_ff <= eng2_led_map[7:0];
            eng3_hi_ff <= hi_byte(eng3_gpo_map, eng3_led_map[8]);
            eng3_lo_ff <= eng3_led_map[7:0];
        end
    end

    assign gain_change_threshold_select = gain_ff[`EMG_GAIN_THR_HI-2:`EMG_GAIN_THR_LO-2];
    assign adaptive_threshold_enable    = gain_ff[`EMG_GAIN_ADAPT_BIT-2];
    assign gain_return_period_select    = gain_ff[`EMG_GAIN_TSEL_HI-2:`EMG_GAIN_TSEL_LO-2];
    assign gain_return_timer_enable     = gain_ff[`EMG_GAIN_TEN_BIT-2];

    emg_gain_timer #(
        .CNT_W    (21),
        .CNT_5MS  (CNT_5MS),
        .CNT_10MS (CNT_10MS),
        .CNT_50MS (CNT_50MS)
    ) u_timer (
        .mclk         (mclk),
        .rst_b        (rst_b),
        .timer_en     (gain_return_timer_enable),
        .period_sel   (gain_return_period_select),
        .gain_is_1p5  (gain_is_1p5),
        .return_1x_ff (gain_return_1x)
    );

endmodule

/* verification/emg_regs_chk_assertions.sv */
`timescale 1ns/1ps
module emg_regs_chk (
    // Clock and reset.
    input wire       mclk,
    input wire       rst_b,
    // Serial bus pins.
    input wire       scl_in,
    input wire       sda_out,
    input wire       sda_oe_ff,
    // Charge pump control.
    input wire       gain_is_1p5,
    input wire [1:0] gain_change_threshold_select,
    input wire       adaptive_threshold_enable,
    input wire [1:0] gain_return_period_select,
    input wire       gain_return_timer_enable,
    input wire       gain_return_1x
);
    wire [5:0] ctl = {gain_change_threshold_select, adaptive_threshold_enable,
                      gain_return_period_select, gain_return_timer_enable};
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    reset_idle_out_a: assert property ($rose(rst_b) |-> !sda_oe_ff && !gain_return_1x && ctl == 6'h00)
        else $error("outputs not idle after reset");
    pulse_gap_a: assert property (gain_return_1x |=> !gain_return_1x [*8])
        else $error("return pulse too long or too close");
    pulse_cause_a: assert property (gain_return_1x |-> $past(gain_return_timer_enable) &&
        $past(gain_is_1p5) && $past(gain_return_period_select) != 2'h3)
        else $error("return pulse without its conditions");
    low_gain_quiet_a: assert property (!gain_is_1p5 ##1 !gain_is_1p5 |-> !gain_return_1x)
        else $error("return pulse while pump not in 1.5x");
    ctrl_low_scl_a: assert property (!$stable(ctl) |-> !scl_in)
        else $error("control outputs changed while clock high");
    oe_low_scl_a: assert property (!$stable(sda_oe_ff) |-> !scl_in)
        else $error("data pin changed while clock high");
    oe_hold_a: assert property ($rose(sda_oe_ff) |=> sda_oe_ff [*4])
        else $error("data pin drive too short");
    sda_drive_low_a: assert property (sda_oe_ff |-> sda_out == 1'b0)
        else $error("data pin driven high");
    ctrl_on_ack_a: assert property (!$stable(ctl) |-> $rose(sda_oe_ff))
        else $error("control outputs changed outside a write acknowledge");
endmodule

/* verification/emg_host_model.sv */
`timescale 1ns/1ps
module emg_host_model (
    // Clock and bus wires.
    input  wire       mclk,
    input  wire       sda_in,
    output reg        scl,
    output reg        sda_oe,
    // Observed results.
    output reg        res_valid,
    output reg  [8:0] res_data
);
    initial begin
        scl = 1'b1;
        sda_oe = 1'b0;
        res_valid = 1'b0;
        res_data = 9'h000;
    end
    task cyc(input integer n);
        repeat (n) @(posedge mclk);
    endtask
    // Start is frame(0,1), stop is frame(1,0); data moves only while the clock is low.
    task frame(input mid, input fin);
        scl <= 1'b0;
        cyc(3);
        sda_oe <= mid;
        cyc(3);
        scl <= 1'b1;
        cyc(6);
        sda_oe <= fin;
        cyc(6);
    endtask
    task bitx(input b, output r);
        scl <= 1'b0;
        cyc(3);
        sda_oe <= ~b;
        cyc(3);
        r = sda_in;
        scl <= 1'b1;
        cyc(6);
    endtask
    // Write bytes report the ack bit, read bytes report the data.
    task xfer(input [7:0] d, input rd, input last);
        reg [7:0] q;
        reg       a;
        integer   k;
        for (k = 7; k >= 0; k = k - 1)
            bitx(rd | d[k], q[k]);
        bitx(rd ? last : 1'b1, a);
        res_data <= rd ? {1'b0, q} : {8'h80, a};
        res_valid <= 1'b1;
        cyc(1);
        res_valid <= 1'b0;
    endtask
endmodule

/* verification/emg_map_gain_regs_tb.sv */
`timescale 1ns/1ps
`include "emg_consts.vh"
`define CHK(nm, x, g) begin total_checks = total_checks + 1; if ((g) !== (x)) begin \
    bad_count = bad_count + 1; $display("ERROR %s expected %h seen %h", nm, x, g); end end
module emg_map_gain_regs_tb;
    localparam [6:0] BASE = `EMG_DEV_ADDR_BASE;
    localparam [8:0] ACK  = 9'h100;
    localparam integer T5  = 20;
    localparam integer T10 = 40;
    localparam integer T50 = 100;
    reg        mclk;
    reg        rst_b;
    reg  [1:0] addr_sel;
    reg        gain_1p5;
    reg  [9:0] m [0:2];
    wire       scl;
    wire       host_oe;
    wire       sda_oe;
    wire       dout;
    wire       sda = (sda_oe ? dout : 1'b1) & ~host_oe;
    wire [5:0] ctl;
    wire       ret_1x;
    wire       res_valid;
    wire [8:0] res_data;
    reg  [8:0] expq [$];
    reg  [8:0] q;
    reg  [7:0] e [0:6];
    reg  [7:0] v;
    reg        ok;
    integer    seed = 32'h6cc0cfec;
    integer    bad_count = 0;
    integer    total_checks = 0;
    integer    i;
    integer    j;
    integer    c;
    emg_map_gain_regs #(.CNT_5MS(T5), .CNT_10MS(T10), .CNT_50MS(T50)) DUT (
        .mclk(mclk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda), .sda_out(dout), .sda_oe_ff(sda_oe),
        .addr_sel(addr_sel), .eng1_led_map(m[0][8:0]), .eng1_gpo_map(m[0][9]),
        .eng2_led_map(m[1][8:0]), .eng2_gpo_map(m[1][9]), .eng3_led_map(m[2][8:0]), .eng3_gpo_map(m[2][9]),
        .gain_is_1p5(gain_1p5), .gain_change_threshold_select(ctl[5:4]), .adaptive_threshold_enable(ctl[3]),
        .gain_return_period_select(ctl[2:1]), .gain_return_timer_enable(ctl[0]), .gain_return_1x(ret_1x));
    emg_host_model host (.mclk(mclk), .sda_in(sda), .scl(scl), .sda_oe(host_oe),
        .res_valid(res_valid), .res_data(res_data));
    always #20 mclk = ~mclk;
    task results;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task acks;
        repeat (3) expq.push_back(ACK);
    endtask
    task wr1(input [7:0] p, input [7:0] d);
        acks();
        host.frame(1'b0, 1'b1);
        host.xfer({BASE[6:2], addr_sel, 1'b0}, 1'b0, 1'b0);
        host.xfer(p, 1'b0, 1'b0);
        host.xfer(d, 1'b0, 1'b0);
        host.frame(1'b1, 1'b0);
    endtask
    task rd(input [7:0] p, input integer n);
        acks();
        for (j = 0; j < n; j = j + 1)
            expq.push_back({1'b0, e[j]});
        host.frame(1'b0, 1'b1);
        host.xfer({BASE[6:2], addr_sel, 1'b0}, 1'b0, 1'b0);
        host.xfer(p, 1'b0, 1'b0);
        host.frame(1'b0, 1'b1);
        host.xfer({BASE[6:2], addr_sel, 1'b1}, 1'b0, 1'b0);
        for (j = 0; j < n; j = j + 1)
            host.xfer(8'hFF, 1'b1, j == n - 1);
        host.frame(1'b1, 1'b0);
    endtask
    // High byte holds pin and output nine, low byte outputs one to eight.
    task mkexp(input [7:0] g);
        integer k;
        for (k = 0; k < 3; k = k + 1) begin
            e[2 * k] = {m[k][9], 6'h00, m[k][8]};
            e[2 * k + 1] = m[k][7:0];
        end
        e[6] = g & 8'hFC;
    endtask
    // Each bus result is compared with the oldest expectation.
    always @(posedge mclk) begin
        if (res_valid === 1'b1) begin
            q = (expq.size() > 0) ? expq.pop_front() : 9'h1FF;
            `CHK("bus result", q, res_data)
        end
    end
    initial begin
        repeat (50000) @(posedge mclk);
        bad_count = bad_count + 1;
        results();
    end
    initial begin
        mclk = 1'b0;
        rst_b = 1'b0;
        addr_sel = 2'h0;
        gain_1p5 = 1'b0;
        for (i = 0; i < 3; i = i + 1)
            m[i] = 10'h000;
        @(posedge mclk);
        addr_sel <= 2'($random(seed));
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (4) @(posedge mclk);
        mkexp(8'h00);
        rd(8'h70, 7);
        `CHK("control reset", 6'h00, ctl)
        for (i = 0; i < 3; i = i + 1) begin
            for (j = 0; j < 3; j = j + 1)
                m[j] <= 10'($random(seed));
            repeat (2) @(posedge mclk);
            mkexp(8'h00);
            rd(8'h70, 7);
        end
        for (i = 0; i < 6; i = i + 1)
            wr1(8'h70 + i[7:0], 8'hFF);
        rd(8'h70, 6);
        expq.push_back(9'h101);
        host.frame(1'b0, 1'b1);
        host.xfer({BASE[6:2], addr_sel ^ 2'h1, 1'b0}, 1'b0, 1'b0);
        host.frame(1'b1, 1'b0);
        for (i = 0; i < 4; i = i + 1) begin
            v = {i[1:0], i[0], ~i[1:0], ~i[0], 2'h3};
            wr1(8'h76, v);
            `CHK("control outputs", v[7:2], ctl)
            e[0] = v & 8'hFC;
            e[1] = 8'h00;
            rd(8'h76, 2);
        end
        for (i = 0; i < 4; i = i + 1) begin
            gain_1p5 <= 1'b0;
            wr1(8'h76, {3'h0, i[1:0], 3'h4});
            gain_1p5 <= 1'b1;
            c = 0;
            while (c < 150 && ret_1x !== 1'b1) begin
                @(negedge mclk);
                c = c + 1;
            end
            @(posedge mclk);
            j = (i == 0) ? T5 : (i == 1) ? T10 : T50;
            ok = (i == 3) ? (c == 150) : (c >= j && c <= j + 2);
            `CHK("return timer", 1'b1, ok)
        end
        gain_1p5 <= 1'b0;
        repeat (20) @(posedge mclk);
        `CHK("pending results", 0, expq.size())
        results();
    end
endmodule
bind emg_map_gain_regs emg_regs_chk u_chk (
    .mclk(mclk), .rst_b(rst_b), .scl_in(scl_in), .sda_out(sda_out), .sda_oe_ff(sda_oe_ff),
    .gain_is_1p5(gain_is_1p5), .gain_change_threshold_select(gain_change_threshold_select),
    .adaptive_threshold_enable(adaptive_threshold_enable), .gain_return_period_select(gain_return_period_select),
    .gain_return_timer_enable(gain_return_timer_enable), .gain_return_1x(gain_return_1x));
